// file: inc/cpm_pkg.sv
// Package with constants and types for the caller-ID port mode selector.
package cpm_pkg;
	// Operating modes chosen from the strap pins.
	typedef enum logic [1:0]
	{
		CPM_MODE_NORMAL,
		CPM_MODE_CALLERID,
		CPM_MODE_PROGRAM,
		CPM_MODE_UNDEFINED
	} cpm_mode_e;

	// Register byte offsets.
	localparam logic [7:0] CPM_OFF_MODE = 8'h00;
	localparam logic [7:0] CPM_OFF_CTRL = 8'h04;
	localparam logic [7:0] CPM_OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] CPM_OFF_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] CPM_OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] CPM_OFF_PINS = 8'h14;

	// Control register field positions.
	localparam int CPM_CTRL_ALT_RESET_SEL = 0;
	localparam int CPM_CTRL_ALT_RESET_VAL = 1;
	localparam int CPM_CTRL_PRIMARY_RESET_VAL = 2;

	// Interrupt status bit positions.
	localparam int CPM_IRQ_RECEIVER_REQ = 0;
	localparam int CPM_IRQ_RECEIVER_RELEASED = 1;
	localparam int CPM_IRQ_COUNT = 2;

	// Values after reset.
	localparam logic [2:0] CPM_CTRL_RESET = 3'h0;
	localparam logic [CPM_IRQ_COUNT-1:0] CPM_IRQ_RESET = 2'h0;

	// AXI4-Lite response codes.
	localparam logic [1:0] CPM_RESP_OKAY = 2'h0;
	localparam logic [1:0] CPM_RESP_SLVERR = 2'h2;
endpackage

// file: inc/cpm_rx_if.sv
// Interface between the mode selector and the receiver reset sequencer.
`timescale 1ns/1ps
interface cpm_rx_if;
	logic hold_low_level;
	logic receiver_in_reset;
	logic released_pulse;

	modport ctrl
	(
		output hold_low_level,
		input receiver_in_reset,
		input released_pulse
	);
	modport seq
	(
		input hold_low_level,
		output receiver_in_reset,
		output released_pulse
	);
endinterface

// file: core/cpm_release_seq.sv
// Receiver reset sequencer: releases only after a high, low, high toggle.
`timescale 1ns/1ps
module cpm_release_seq
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	cpm_rx_if.seq rx
);
	typedef enum logic [1:0]
	{
		CPM_SEQ_WAIT_HIGH,
		CPM_SEQ_WAIT_LOW,
		CPM_SEQ_WAIT_RISE,
		CPM_SEQ_RELEASED
	} cpm_seq_e;

	cpm_seq_e state;
	cpm_seq_e next_state;

	always_comb
	begin
		next_state = state;
		case (state)
			CPM_SEQ_WAIT_HIGH:
				if (rx.hold_low_level)
					next_state = CPM_SEQ_WAIT_LOW;
			CPM_SEQ_WAIT_LOW:
				if (!rx.hold_low_level)
					next_state = CPM_SEQ_WAIT_RISE;
			CPM_SEQ_WAIT_RISE:
				if (rx.hold_low_level)
					next_state = CPM_SEQ_RELEASED;
			default:
				if (!rx.hold_low_level)
					next_state = CPM_SEQ_WAIT_RISE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state <= CPM_SEQ_WAIT_HIGH;
		else
			state <= next_state;
	end

	assign rx.receiver_in_reset = (state != CPM_SEQ_RELEASED);
	assign rx.released_pulse = (state == CPM_SEQ_WAIT_RISE) && (next_state == CPM_SEQ_RELEASED);
endmodule

// file: core/cpm_mode_select.sv
// Top of the caller-ID port mode selector with its AXI4-Lite register file.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Test and reset pins select operating mode.
// - Normal mode links core and receiver by ports.
// - Request P1.0, clock P2.1, data P2.2.
// - Receiver reset from P3.1, or P8.0 if P8.1.
// - Receiver leaves reset only after high-low-high toggle.
// - Caller-ID mode disables core, four pins dedicated.
// - Caller-ID pins P9.0, P9.1, P9.2, P1.1.
// - Request and data pins open-drain in caller-ID mode.
module cpm_mode_select
(
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic I_TEST_PIN,
	input wire logic I_CHIP_RESET_LOW_PIN,
	output logic O_CORE_ENABLE,
	output logic [1:0] O_MODE,
	input wire logic I_CORE_P3_1,
	input wire logic I_CORE_P8_0,
	input wire logic I_CORE_P8_1,
	output logic O_CORE_P1_0,
	output logic O_CORE_P2_2,
	input wire logic I_CORE_P2_1,
	input wire logic I_CORE_P2_2_OUT,
	input wire logic I_CORE_P2_2_OE_N,
	input wire logic I_RX_REQ,
	output logic O_RX_CLOCK,
	input wire logic I_RX_DATA_OUT,
	input wire logic I_RX_DATA_OE_N,
	output logic O_RX_DATA_IN,
	output logic O_RECEIVER_HOLD_LOW,
	input wire logic I_P9_0,
	output logic O_P9_0,
	output logic O_P9_0_OE_N,
	input wire logic I_P9_1,
	input wire logic I_P9_2,
	output logic O_P9_2,
	output logic O_P9_2_OE_N,
	input wire logic I_P1_1,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_IRQ
);
	cpm_pkg::cpm_mode_e mode;
	logic mode_taken;
	logic [2:0] ctrl;
	logic [cpm_pkg::CPM_IRQ_COUNT-1:0] irq_status;
	logic [cpm_pkg::CPM_IRQ_COUNT-1:0] irq_enable;
	logic [cpm_pkg::CPM_IRQ_COUNT-1:0] irq_event;
	logic [cpm_pkg::CPM_IRQ_COUNT-1:0] irq_clear;
	logic req_seen;
	logic callerid;
	logic hold_low_source;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Carries the selected reset level to the sequencer and its state back.
	cpm_rx_if rx_link();

	// The sequencer enforces the high, low, high toggle before release.
	cpm_release_seq u_release_seq
	(
		.i_clock(I_CLOCK),
		.i_reset_n(I_RESET_N),
		.rx(rx_link)
	);

	// The strap pins are caught once, at the first edge after reset release.
	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			mode <= cpm_pkg::CPM_MODE_NORMAL;
			mode_taken <= 1'b0;
		end
		else if (!mode_taken)
		begin
			mode_taken <= 1'b1;
			if (!I_TEST_PIN && I_CHIP_RESET_LOW_PIN)
				mode <= cpm_pkg::CPM_MODE_NORMAL;
			else if (I_TEST_PIN && !I_CHIP_RESET_LOW_PIN)
				mode <= cpm_pkg::CPM_MODE_CALLERID;
			else
				mode <= cpm_pkg::CPM_MODE_PROGRAM;
		end
	end

	assign callerid = (mode == cpm_pkg::CPM_MODE_CALLERID);
	assign O_MODE = mode;
	// The core runs only in normal mode, and only once the straps are taken.
	assign O_CORE_ENABLE = mode_taken && (mode == cpm_pkg::CPM_MODE_NORMAL);

	// Receiver reset source: core port bits in normal mode, a pin in caller-ID mode.
	always_comb
	begin
		if (callerid)
			hold_low_source = I_P1_1;
		else if (I_CORE_P8_1)
			hold_low_source = I_CORE_P8_0;
		else
			hold_low_source = I_CORE_P3_1;
	end

	// The sequencer watches the source only once the straps are taken, so the
	// routing in force before capture cannot count towards the release toggle.
	assign rx_link.hold_low_level = hold_low_source && mode_taken;
	assign O_RECEIVER_HOLD_LOW = hold_low_source && !rx_link.receiver_in_reset;

	// Signal routing between receiver and either the core or the dedicated pins.
	assign O_CORE_P1_0 = callerid ? 1'b0 : I_RX_REQ;
	assign O_RX_CLOCK = callerid ? I_P9_1 : I_CORE_P2_1;
	// Data is a wired-AND: any party driving low pulls the line low.
	always_comb
	begin
		if (callerid)
			O_RX_DATA_IN = I_P9_2 && (I_RX_DATA_OE_N || I_RX_DATA_OUT);
		else
			O_RX_DATA_IN = (I_CORE_P2_2_OE_N || I_CORE_P2_2_OUT)
				&& (I_RX_DATA_OE_N || I_RX_DATA_OUT);
	end
	assign O_CORE_P2_2 = callerid ? 1'b1 : (I_RX_DATA_OE_N || I_RX_DATA_OUT);

	// Open drain: only a low is driven, a high is left to the pull-up.
	assign O_P9_0 = 1'b0;
	assign O_P9_0_OE_N = !(callerid && !I_RX_REQ);
	assign O_P9_2 = 1'b0;
	assign O_P9_2_OE_N = !(callerid && !I_RX_DATA_OE_N && !I_RX_DATA_OUT);

	// Interrupt events: request rising edge and receiver release.
	// The request line idles high behind its pull-up; starting at that level
	// keeps a false edge from being logged right after reset.
	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			req_seen <= 1'b1;
		else
			req_seen <= I_RX_REQ;
	end

	assign irq_event[cpm_pkg::CPM_IRQ_RECEIVER_REQ] = I_RX_REQ && !req_seen;
	assign irq_event[cpm_pkg::CPM_IRQ_RECEIVER_RELEASED] = rx_link.released_pulse;
	// Write-one-to-clear, decoded from the held write.
	assign irq_clear = (do_write && aw_addr == cpm_pkg::CPM_OFF_IRQ_CLEAR && w_strb[0])
		? w_data[cpm_pkg::CPM_IRQ_COUNT-1:0] : '0;

	// One sticky status bit per event source.
	genvar gi;
	generate
		for (gi = 0; gi < cpm_pkg::CPM_IRQ_COUNT; gi++)
		begin : g_irq
			// A new event in the clearing cycle keeps its bit set.
			always_ff @(posedge I_CLOCK or negedge I_RESET_N)
			begin
				if (!I_RESET_N)
					irq_status[gi] <= 1'b0;
				else if (irq_event[gi])
					irq_status[gi] <= 1'b1;
				else if (irq_clear[gi])
					irq_status[gi] <= 1'b0;
			end
		end
	endgenerate

	// Level interrupt: high while any enabled status bit is set.
	assign O_IRQ = |(irq_status & irq_enable);

	// AXI4-Lite write side: address and data captured independently.
	assign O_AWREADY = !aw_held;
	assign O_WREADY = !w_held;
	// A write is performed once both halves are held and no response is pending.
	assign do_write = aw_held && w_held && !O_BVALID;

	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			O_BVALID <= 1'b0;
			O_BRESP <= cpm_pkg::CPM_RESP_OKAY;
		end
		else
		begin
			if (I_AWVALID && O_AWREADY)
			begin
				aw_held <= 1'b1;
				aw_addr <= I_AWADDR;
			end
			if (I_WVALID && O_WREADY)
			begin
				w_held <= 1'b1;
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
			end
			if (do_write)
			begin
				O_BVALID <= 1'b1;
				if (aw_addr == cpm_pkg::CPM_OFF_CTRL || aw_addr == cpm_pkg::CPM_OFF_IRQ_CLEAR
					|| aw_addr == cpm_pkg::CPM_OFF_IRQ_ENABLE)
					O_BRESP <= cpm_pkg::CPM_RESP_OKAY;
				else
					O_BRESP <= cpm_pkg::CPM_RESP_SLVERR;
			end
			// The response handshake frees both capture slots for the next write.
			else if (O_BVALID && I_BREADY)
			begin
				O_BVALID <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// Writable registers; only the low byte lane carries any bits.
	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ctrl <= cpm_pkg::CPM_CTRL_RESET;
			irq_enable <= cpm_pkg::CPM_IRQ_RESET;
		end
		else if (do_write && w_strb[0])
		begin
			if (aw_addr == cpm_pkg::CPM_OFF_CTRL)
				ctrl <= w_data[2:0];
			else if (aw_addr == cpm_pkg::CPM_OFF_IRQ_ENABLE)
				irq_enable <= w_data[cpm_pkg::CPM_IRQ_COUNT-1:0];
		end
	end

	// AXI4-Lite read side: one read at a time, answered the cycle after the address.
	assign O_ARREADY = !O_RVALID;

	always_comb
	begin
		next_rresp = cpm_pkg::CPM_RESP_OKAY;
		next_rdata = 32'h0000_0000;
		if (I_ARADDR == cpm_pkg::CPM_OFF_MODE)
			next_rdata = {29'h0, mode_taken, mode};
		else if (I_ARADDR == cpm_pkg::CPM_OFF_CTRL)
			next_rdata = {29'h0, ctrl};
		else if (I_ARADDR == cpm_pkg::CPM_OFF_IRQ_STATUS)
			next_rdata = {30'h0, irq_status};
		else if (I_ARADDR == cpm_pkg::CPM_OFF_IRQ_CLEAR)
			next_rdata = 32'h0000_0000;
		else if (I_ARADDR == cpm_pkg::CPM_OFF_IRQ_ENABLE)
			next_rdata = {30'h0, irq_enable};
		else if (I_ARADDR == cpm_pkg::CPM_OFF_PINS)
			next_rdata = {26'h0, rx_link.receiver_in_reset, hold_low_source, I_RX_REQ,
				callerid, I_TEST_PIN, I_CHIP_RESET_LOW_PIN};
		// Unmapped offsets answer with an error and read as zero.
		else
			next_rresp = cpm_pkg::CPM_RESP_SLVERR;
		// Valid rises on an accepted address and holds until the master takes it.
		next_rvalid = O_RVALID ? !I_RREADY : I_ARVALID;
	end

	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= cpm_pkg::CPM_RESP_OKAY;
		end
		else
		begin
			O_RVALID <= next_rvalid;
			// Data is captured with the address so it stands until it is taken.
			if (I_ARVALID && O_ARREADY)
			begin
				O_RDATA <= next_rdata;
				O_RRESP <= next_rresp;
			end
		end
	end
endmodule

// file: test/cpm_rx_model.sv
// Behavioural model of the caller-ID receiver seen across the port mux.
`timescale 1ns/1ps
module cpm_rx_model
(
	input wire logic i_hold_low,
	input wire logic i_req_cmd,
	input wire logic i_drive_cmd,
	output logic o_req,
	output logic o_data_out,
	output logic o_data_oe_n
);
	// While held in reset the receiver leaves its request and data lines released.
	assign o_req = !(i_hold_low && i_req_cmd);
	assign o_data_out = 1'h0;
	assign o_data_oe_n = !(i_hold_low && i_drive_cmd);
endmodule

// file: test/cpm_mode_select_props.sv
// Concurrent checks on the ports of the caller-ID port mode selector.
`timescale 1ns/1ps
module cpm_props
(
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic I_TEST_PIN,
	input wire logic I_CHIP_RESET_LOW_PIN,
	input wire logic O_CORE_ENABLE,
	input wire logic [1:0] O_MODE,
	input wire logic I_CORE_P3_1,
	input wire logic I_CORE_P8_0,
	input wire logic I_CORE_P8_1,
	input wire logic O_CORE_P1_0,
	input wire logic O_CORE_P2_2,
	input wire logic I_CORE_P2_1,
	input wire logic I_RX_REQ,
	input wire logic O_RX_CLOCK,
	input wire logic I_RX_DATA_OUT,
	input wire logic I_RX_DATA_OE_N,
	input wire logic O_RECEIVER_HOLD_LOW,
	input wire logic O_P9_0,
	input wire logic O_P9_0_OE_N,
	input wire logic I_P9_1,
	input wire logic O_P9_2,
	input wire logic O_P9_2_OE_N,
	input wire logic I_P1_1
);
	logic [1:0] strap_mode;
	logic src;
	logic seen_low;
	assign strap_mode = I_TEST_PIN ? (I_CHIP_RESET_LOW_PIN ? 2'h2 : 2'h1)
		: (I_CHIP_RESET_LOW_PIN ? 2'h0 : 2'h2);
	assign src = O_MODE == 2'h1 ? I_P1_1 : (I_CORE_P8_1 ? I_CORE_P8_0 : I_CORE_P3_1);
	// Remembers that the receiver reset source has been low since chip reset.
	always_ff @(posedge I_CLOCK or negedge I_RESET_N)
		if (!I_RESET_N)
			seen_low <= 1'h0;
		else if (!src)
			seen_low <= 1'h1;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESET_N);
	property p_mode_pick;
		$rose(I_RESET_N) |=> O_MODE == $past(strap_mode);
	endproperty
	a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from straps");
	property p_mode_hold;
		$past(I_RESET_N) && $past(I_RESET_N, 2) |-> $stable(O_MODE)
			&& O_CORE_ENABLE == (O_MODE == 2'h0);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");
	property p_norm_route;
		O_CORE_ENABLE |-> O_CORE_P1_0 == I_RX_REQ && O_RX_CLOCK == I_CORE_P2_1;
	endproperty
	a_norm_route: assert property (p_norm_route) else $error("normal routing wrong");
	property p_cid_req;
		O_MODE == 2'h1 |-> O_RX_CLOCK == I_P9_1 && !O_P9_0 && O_P9_0_OE_N == I_RX_REQ;
	endproperty
	a_cid_req: assert property (p_cid_req) else $error("request pin wrong");
	property p_cid_data;
		O_MODE == 2'h1 |-> !O_P9_2 && O_P9_2_OE_N == (I_RX_DATA_OE_N || I_RX_DATA_OUT);
	endproperty
	a_cid_data: assert property (p_cid_data) else $error("data pin not open drain");
	property p_cid_core;
		O_MODE == 2'h1 |-> !O_CORE_ENABLE && !O_CORE_P1_0 && O_CORE_P2_2;
	endproperty
	a_cid_core: assert property (p_cid_core) else $error("core side active");
	property p_hold_src;
		O_RECEIVER_HOLD_LOW |-> src;
	endproperty
	a_hold_src: assert property (p_hold_src) else $error("reset source ignored");
	property p_release;
		$rose(O_RECEIVER_HOLD_LOW) |-> seen_low;
	endproperty
	a_release: assert property (p_release) else $error("release without toggle");
	cover property (O_MODE == 2'h1 && O_RECEIVER_HOLD_LOW);
	cover property ($rose(O_RECEIVER_HOLD_LOW) && O_CORE_ENABLE);
	cover property (O_MODE == 2'h2);
endmodule
bind cpm_mode_select cpm_props u_props (.I_CLOCK, .I_RESET_N, .I_TEST_PIN,
	.I_CHIP_RESET_LOW_PIN, .O_CORE_ENABLE, .O_MODE, .I_CORE_P3_1, .I_CORE_P8_0,
	.I_CORE_P8_1, .O_CORE_P1_0, .O_CORE_P2_2, .I_CORE_P2_1, .I_RX_REQ, .O_RX_CLOCK,
	.I_RX_DATA_OUT, .I_RX_DATA_OE_N, .O_RECEIVER_HOLD_LOW, .O_P9_0, .O_P9_0_OE_N,
	.I_P9_1, .O_P9_2, .O_P9_2_OE_N, .I_P1_1);

// file: test/tb_callerid_port_mode_select.sv
// Self-checking bench for the caller-ID port mode selector.
`timescale 1ns/1ps
module tb_callerid_port_mode_select;
	logic O_CORE_ENABLE, O_CORE_P1_0, O_CORE_P2_2, O_RX_CLOCK, O_RX_DATA_IN, O_IRQ;
	logic O_RECEIVER_HOLD_LOW, O_P9_0, O_P9_0_OE_N, O_P9_2, O_P9_2_OE_N;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
	logic [1:0] O_MODE, O_BRESP, O_RRESP;
	logic [31:0] O_RDATA;
	logic I_CLOCK = 1'h0, I_RESET_N = 1'h0, I_TEST_PIN = 1'h0, I_CHIP_RESET_LOW_PIN = 1'h1;
	logic I_CORE_P8_1 = 1'h0, I_CORE_P2_1 = 1'h0, I_CORE_P2_2_OE_N = 1'h1, I_P9_1 = 1'h0;
	logic I_AWVALID = 1'h0, I_WVALID = 1'h0, I_BREADY = 1'h0, I_ARVALID = 1'h0;
	logic I_RREADY = 1'h0, sv = 1'h0, rq = 1'h0, dv = 1'h0;
	logic [1:0] sel = 2'h0;
	logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	wire I_RX_REQ, I_RX_DATA_OUT, I_RX_DATA_OE_N;
	wire I_CORE_P3_1 = sel == 2'h0 && sv;
	wire I_CORE_P8_0 = sel == 2'h1 && sv;
	wire I_P1_1 = sel == 2'h2 && sv;
	// Open-drain pins with pull-ups.
	wire I_P9_0 = O_P9_0_OE_N | O_P9_0;
	wire I_P9_2 = O_P9_2_OE_N | O_P9_2;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	cpm_mode_select dut_u (.I_CLOCK, .I_RESET_N, .I_TEST_PIN, .I_CHIP_RESET_LOW_PIN,
		.O_CORE_ENABLE, .O_MODE, .I_CORE_P3_1, .I_CORE_P8_0, .I_CORE_P8_1, .O_CORE_P1_0,
		.O_CORE_P2_2, .I_CORE_P2_1, .I_CORE_P2_2_OUT(1'h0), .I_CORE_P2_2_OE_N, .I_RX_REQ,
		.O_RX_CLOCK, .I_RX_DATA_OUT, .I_RX_DATA_OE_N, .O_RX_DATA_IN, .O_RECEIVER_HOLD_LOW,
		.I_P9_0, .O_P9_0, .O_P9_0_OE_N, .I_P9_1, .I_P9_2, .O_P9_2, .O_P9_2_OE_N, .I_P1_1,
		.I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB(4'hF), .I_WVALID, .O_WREADY,
		.O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
		.O_RRESP, .O_RVALID, .I_RREADY, .O_IRQ);
	cpm_rx_model rx_u (.i_hold_low(O_RECEIVER_HOLD_LOW), .i_req_cmd(rq), .i_drive_cmd(dv),
		.o_req(I_RX_REQ), .o_data_out(I_RX_DATA_OUT), .o_data_oe_n(I_RX_DATA_OE_N));
	always #10 I_CLOCK = !I_CLOCK;
	always @(posedge I_CLOCK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			test_done();
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task rst(input logic t, input logic p);
		@(posedge I_CLOCK);
		I_RESET_N <= 1'h0;
		I_TEST_PIN <= t;
		I_CHIP_RESET_LOW_PIN <= p;
		repeat (16) @(posedge I_CLOCK);
		I_RESET_N <= 1'h1;
		repeat (2) @(negedge I_CLOCK);
	endtask
	task rel;
		@(posedge I_CLOCK);
		sv <= 1'h1;
		@(posedge I_CLOCK);
		sv <= 1'h0;
		@(negedge I_CLOCK);
		chk("hold", O_RECEIVER_HOLD_LOW, 0);
		@(posedge I_CLOCK);
		sv <= 1'h1;
		for (int i = 0; i < 8 && O_RECEIVER_HOLD_LOW !== 1'h1; i++)
			@(negedge I_CLOCK);
		chk("released", O_RECEIVER_HOLD_LOW, 1);
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge I_CLOCK);
		I_AWADDR <= a;
		I_WDATA <= d;
		I_AWVALID <= 1'h1;
		I_WVALID <= 1'h1;
		I_BREADY <= 1'h1;
		do
		begin
			@(posedge I_CLOCK);
			if (O_AWREADY)
				I_AWVALID <= 1'h0;
			if (O_WREADY)
				I_WVALID <= 1'h0;
		end
		while (O_BVALID !== 1'h1);
		chk("bresp", O_BRESP, e);
		I_BREADY <= 1'h0;
		@(negedge I_CLOCK);
	endtask
	task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge I_CLOCK);
		I_ARADDR <= a;
		I_ARVALID <= 1'h1;
		I_RREADY <= 1'h1;
		do
		begin
			@(posedge I_CLOCK);
			if (O_ARREADY)
				I_ARVALID <= 1'h0;
		end
		while (O_RVALID !== 1'h1);
		chk("rresp", O_RRESP, e);
		if (e == 2'h0)
			chk("rdata", O_RDATA, d);
		I_RREADY <= 1'h0;
	endtask
	task t_normal;
		rst(1'h0, 1'h1);
		chk("mode", O_MODE, 0);
		chk("core on", O_CORE_ENABLE, 1);
		rel();
		for (int v = 0; v < 2; v++)
		begin
			@(posedge I_CLOCK);
			I_CORE_P2_1 <= v[0];
			I_CORE_P2_2_OE_N <= !v[0];
			rq <= v[0];
			dv <= v[0];
			@(negedge I_CLOCK);
			chk("clock", O_RX_CLOCK, v);
			chk("request", O_CORE_P1_0, !v[0]);
			chk("core data", O_CORE_P2_2, !v[0]);
			chk("rx data", O_RX_DATA_IN, !v[0]);
			chk("pins off", {O_P9_0_OE_N, O_P9_2_OE_N}, 3);
		end
		@(posedge I_CLOCK);
		sel <= 2'h1;
		I_CORE_P8_1 <= 1'h1;
		@(negedge I_CLOCK);
		chk("alt source", O_RECEIVER_HOLD_LOW, 1);
		@(posedge I_CLOCK);
		sv <= 1'h0;
		@(negedge I_CLOCK);
		chk("alt low", O_RECEIVER_HOLD_LOW, 0);
		@(posedge I_CLOCK);
		I_TEST_PIN <= 1'h1;
		I_CHIP_RESET_LOW_PIN <= 1'h0;
		repeat (2) @(negedge I_CLOCK);
		chk("mode kept", O_MODE, 0);
		$display("normal mode test done");
	endtask
	task t_regs;
		@(posedge I_CLOCK);
		rq <= 1'h0;
		dv <= 1'h0;
		axr(8'h00, 4, 0);
		axr(8'h04, 0, 0);
		axw(8'h04, 7, 0);
		axr(8'h04, 7, 0);
		axw(8'h00, 1, 2);
		axw(8'h40, 1, 2);
		axr(8'h40, 0, 2);
		axw(8'h0C, 3, 0);
		axr(8'h08, 0, 0);
		axw(8'h10, 1, 0);
		rel();
		chk("irq masked", O_IRQ, 0);
		@(posedge I_CLOCK);
		rq <= 1'h1;
		@(posedge I_CLOCK);
		rq <= 1'h0;
		repeat (2) @(negedge I_CLOCK);
		chk("irq", O_IRQ, 1);
		axr(8'h08, 3, 0);
		axw(8'h0C, 1, 0);
		chk("irq cleared", O_IRQ, 0);
		axw(8'h10, 3, 0);
		chk("irq enabled", O_IRQ, 1);
		axw(8'h0C, 2, 0);
		chk("irq off", O_IRQ, 0);
		axr(8'h0C, 0, 0);
		$display("register test done");
	endtask
	task t_cid;
		rst(1'h1, 1'h0);
		@(posedge I_CLOCK);
		sel <= 2'h2;
		I_CORE_P8_1 <= 1'h0;
		rq <= 1'h0;
		dv <= 1'h0;
		@(negedge I_CLOCK);
		chk("mode", O_MODE, 1);
		chk("core off", O_CORE_ENABLE, 0);
		rel();
		for (int v = 0; v < 2; v++)
		begin
			@(posedge I_CLOCK);
			I_P9_1 <= v[0];
			rq <= v[0];
			dv <= v[0];
			@(negedge I_CLOCK);
			chk("pin clock", O_RX_CLOCK, v);
			chk("pin request", {O_P9_0_OE_N, O_P9_0}, {!v[0], 1'h0});
			chk("pin data", {O_P9_2_OE_N, O_P9_2}, {!v[0], 1'h0});
			chk("rx data", O_RX_DATA_IN, !v[0]);
			chk("core side", {O_CORE_P1_0, O_CORE_P2_2}, 1);
		end
		$display("caller-ID mode test done");
	endtask
	task t_prog;
		rst(1'h1, 1'h1);
		chk("mode", O_MODE, 2);
		rst(1'h0, 1'h0);
		chk("mode", O_MODE, 2);
		chk("core off", O_CORE_ENABLE, 0);
		$display("programming mode test done");
	endtask
	initial
	begin
		t_normal();
		t_regs();
		t_cid();
		t_prog();
		test_done();
	end
endmodule
